// >>> verilog/adcs_consts.svh
// register offsets, field positions and timing counts of the conversion sequencer
`ifndef ADCS_CONSTS_SVH
`define ADCS_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADCS_OFF_CTRL 4'h0
`define ADCS_OFF_COMMAND 4'h1
`define ADCS_OFF_CHANSEL 4'h2
`define ADCS_OFF_REFCFG 4'h3
`define ADCS_OFF_SAMPCFG 4'h4
`define ADCS_OFF_EVCTRL 4'h5
`define ADCS_OFF_INTCTRL 4'h6
`define ADCS_OFF_FLAGS 4'h7
`define ADCS_OFF_RESULT 4'h8
`define ADCS_OFF_ACTIVE 4'h9

// ----------------------------------------
// field positions
// ----------------------------------------
`define ADCS_BIT_ENABLE 0
`define ADCS_BIT_FREERUN 1
`define ADCS_BIT_START 0
`define ADCS_BIT_EVSTART 0
`define ADCS_BIT_RDYIE 0
`define ADCS_BIT_RDYFLAG 0
`define ADCS_REF_LSB 0
`define ADCS_DIV_LSB 4
`define ADCS_SDLY_LSB 0
`define ADCS_SLEN_LSB 4
`define ADCS_ACT_REF_LSB 8

// ----------------------------------------
// reset values and timing counts
// ----------------------------------------
`define ADCS_RST_STATE 16'h0000
`define ADCS_CONV_CYCLES 6'd13
`define ADCS_HOLD_CYCLES 6'd2
`define ADCS_START_EXTRA 9'h002
`define ADCS_FULL_SCALE 10'h3ff

`endif

// >>> verilog/adcs_pkg.sv
// types shared by the conversion sequencer and its prescaler
package adcs_pkg;

    typedef enum logic [1:0] {
        ADCS_ST_IDLE = 2'b00,
        ADCS_ST_WAIT = 2'b01,
        ADCS_ST_CONV = 2'b11
    } adcs_state_t;

    typedef enum logic [1:0] {
        ADCS_REF_INTERNAL = 2'h0,
        ADCS_REF_SUPPLY = 2'h1,
        ADCS_REF_EXTERNAL_PIN = 2'h2
    } adcs_ref_t;

    typedef struct packed {
        logic [4:0] input_channel_select;
        logic [1:0] reference_select;
    } adcs_sel_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } adcs_bus_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } adcs_clock_divider_select_t;

    typedef struct packed {
        adcs_state_t state;
        logic run;
        logic [5:0] cnt;
        logic enable;
        logic freerun;
        logic start;
        logic evstart;
        logic rdy_ie;
        logic flag;
        adcs_sel_t hold_sel;
        adcs_sel_t active_sel;
        logic [2:0] div_sel;
        logic [3:0] sdly;
        logic [3:0] slen;
        logic [9:0] result;
        logic [1:0] ev_sync;
        logic ev_prev;
        logic [15:0] rd_data;
        logic irq;
        logic res_event;
        logic hold_pulse;
    } adcs_core_t;

endpackage

// >>> verilog/adcs_prescaler.sv
// converter clock prescaler: one-cycle pulse at each converter-clock rising edge
`timescale 1ns/10ps

module adcs_prescaler
    import adcs_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic run_in,
    input wire logic [2:0] clock_divider_select_in,
    output logic tick_out
);

    adcs_clock_divider_select_t s_reg;
    adcs_clock_divider_select_t s_next;
    logic [8:0] factor;
    logic [8:0] half;

    // division factor 2, 4, ... 256
    assign factor = 9'h002 << clock_divider_select_in;
    assign half = factor >> 1;

    always_comb
    begin
        s_next = s_reg;
        if (!run_in)
        begin
            // counter held at zero while idle or disabled
            s_next.cnt = 8'h00;
            s_next.tick = 1'b0;
        end
        else
        begin
            s_next.tick = ({1'b0, s_reg.cnt} == (half - 9'h001));
            if ({1'b0, s_reg.cnt} == (factor - 9'h001))
            begin
                s_next.cnt = 8'h00;
            end
            else
            begin
                s_next.cnt = s_reg.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign tick_out = s_reg.tick;

endmodule // adcs_prescaler

// >>> verilog/adcs_sequencer.sv
// conversion sequencer: triggers, timing, channel locking, result flag and registers
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/10ps
`include "adcs_consts.svh"

module adcs_sequencer
    import adcs_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire adcs_bus_t bus_in,
    output logic [15:0] rd_data_out,
    input wire logic global_int_enable_in,
    input wire logic event_in,
    input wire logic [9:0] sar_result_in,
    input wire logic over_range_in,
    output adcs_sel_t active_sel_out,
    output logic sample_hold_out,
    output logic conv_active_out,
    output logic result_event_out,
    output logic irq_out
);

    adcs_core_t s_reg;
    adcs_core_t s_next;
    logic tick;
    logic [5:0] total;
    logic [5:0] sample_end;
    logic ev_edge;
    logic wr_hit;
    logic start_req;
    logic flag_set;
    logic flag_clr;
    logic complete;
    logic track;

    // ----------------------------------------
    // converter clock
    // ----------------------------------------
    // prescaler from divider select
    adcs_prescaler u_clock_divider_select (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .run_in(s_reg.run),
        .clock_divider_select_in(s_reg.div_sel),
        .tick_out(tick)
    );

    // ----------------------------------------
    // timing figures
    // ----------------------------------------
    // cycle length with extensions
    assign total = `ADCS_CONV_CYCLES + {2'b00, s_reg.sdly} + {2'b00, s_reg.slen};
    assign sample_end = `ADCS_HOLD_CYCLES + {2'b00, s_reg.sdly} + {2'b00, s_reg.slen};

    // rising edge after synchroniser
    // only the second flop feeds the detector, so a slow event pin cannot make a runt edge
    assign ev_edge = s_reg.ev_sync[1] & ~s_reg.ev_prev;

    // completion is the tick that closes the last converter cycle
    assign complete = (s_reg.state == ADCS_ST_CONV) && tick && (s_reg.cnt == (total - 6'd1));

    always_comb
    begin
        s_next = s_reg;
        s_next.res_event = 1'b0;
        s_next.hold_pulse = 1'b0;
        s_next.rd_data = 16'h0000;
        s_next.ev_sync = {s_reg.ev_sync[0], event_in};
        s_next.ev_prev = s_reg.ev_sync[1];
        wr_hit = 1'b0;
        start_req = 1'b0;
        flag_set = 1'b0;
        flag_clr = 1'b0;

        // ----------------------------------------
        // register writes
        // ----------------------------------------
        if (bus_in.wr)
        begin
            case (bus_in.addr)
                `ADCS_OFF_CTRL:
                begin
                    s_next.enable = bus_in.wdata[`ADCS_BIT_ENABLE];
                    s_next.freerun = bus_in.wdata[`ADCS_BIT_FREERUN];
                end
                `ADCS_OFF_COMMAND:
                begin
                    wr_hit = bus_in.wdata[`ADCS_BIT_START];
                end
                `ADCS_OFF_CHANSEL:
                begin
                    s_next.hold_sel.input_channel_select = bus_in.wdata[4:0];
                end
                `ADCS_OFF_REFCFG:
                begin
                    s_next.hold_sel.reference_select = bus_in.wdata[`ADCS_REF_LSB +: 2];
                    s_next.div_sel = bus_in.wdata[`ADCS_DIV_LSB +: 3];
                end
                `ADCS_OFF_SAMPCFG:
                begin
                    s_next.sdly = bus_in.wdata[`ADCS_SDLY_LSB +: 4];
                    s_next.slen = bus_in.wdata[`ADCS_SLEN_LSB +: 4];
                end
                `ADCS_OFF_EVCTRL:
                begin
                    s_next.evstart = bus_in.wdata[`ADCS_BIT_EVSTART];
                end
                `ADCS_OFF_INTCTRL:
                begin
                    s_next.rdy_ie = bus_in.wdata[`ADCS_BIT_RDYIE];
                end
                `ADCS_OFF_FLAGS:
                begin
                    flag_clr = bus_in.wdata[`ADCS_BIT_RDYFLAG];
                end
                default:
                begin
                    wr_hit = 1'b0;
                end
            endcase
        end

        // ----------------------------------------
        // register reads, data valid next cycle
        // ----------------------------------------
        if (bus_in.rd)
        begin
            case (bus_in.addr)
                `ADCS_OFF_CTRL:
                begin
                    s_next.rd_data[`ADCS_BIT_ENABLE] = s_reg.enable;
                    s_next.rd_data[`ADCS_BIT_FREERUN] = s_reg.freerun;
                end
                `ADCS_OFF_COMMAND:
                begin
                    // start bit reads one while running
                    s_next.rd_data[`ADCS_BIT_START] = s_reg.start;
                end
                `ADCS_OFF_CHANSEL:
                begin
                    s_next.rd_data[4:0] = s_reg.hold_sel.input_channel_select;
                end
                `ADCS_OFF_REFCFG:
                begin
                    s_next.rd_data[`ADCS_REF_LSB +: 2] = s_reg.hold_sel.reference_select;
                    s_next.rd_data[`ADCS_DIV_LSB +: 3] = s_reg.div_sel;
                end
                `ADCS_OFF_SAMPCFG:
                begin
                    s_next.rd_data[`ADCS_SDLY_LSB +: 4] = s_reg.sdly;
                    s_next.rd_data[`ADCS_SLEN_LSB +: 4] = s_reg.slen;
                end
                `ADCS_OFF_EVCTRL:
                begin
                    s_next.rd_data[`ADCS_BIT_EVSTART] = s_reg.evstart;
                end
                `ADCS_OFF_INTCTRL:
                begin
                    s_next.rd_data[`ADCS_BIT_RDYIE] = s_reg.rdy_ie;
                end
                `ADCS_OFF_FLAGS:
                begin
                    s_next.rd_data[`ADCS_BIT_RDYFLAG] = s_reg.flag;
                end
                `ADCS_OFF_RESULT:
                begin
                    s_next.rd_data[9:0] = s_reg.result;
                    flag_clr = 1'b1;
                end
                `ADCS_OFF_ACTIVE:
                begin
                    s_next.rd_data[4:0] = s_reg.active_sel.input_channel_select;
                    s_next.rd_data[`ADCS_ACT_REF_LSB +: 2] = s_reg.active_sel.reference_select;
                end
                default:
                begin
                    s_next.rd_data = 16'h0000;
                end
            endcase
        end

        // ----------------------------------------
        // start requests
        // ----------------------------------------
        // routed event starts conversion
        // request while busy only keeps bit set
        start_req = wr_hit | (ev_edge & s_reg.evstart);
        if (start_req && s_reg.enable)
        begin
            s_next.start = 1'b1;
        end

        // ----------------------------------------
        // sequencing
        // ----------------------------------------
        case (s_reg.state)
            ADCS_ST_IDLE:
            begin
                if (s_reg.start)
                begin
                    s_next.state = ADCS_ST_WAIT;
                end
            end
            ADCS_ST_WAIT:
            begin
                if (tick)
                begin
                    s_next.state = ADCS_ST_CONV;
                    s_next.cnt = 6'd0;
                end
            end
            ADCS_ST_CONV:
            begin
                if (tick)
                begin
                    if (s_reg.cnt == (sample_end - 6'd1))
                    begin
                        s_next.hold_pulse = 1'b1;
                    end
                    if (complete)
                    begin
                        s_next.result = over_range_in ? `ADCS_FULL_SCALE : sar_result_in;
                        flag_set = 1'b1;
                        s_next.res_event = 1'b1;
                        if (s_reg.freerun && s_reg.start)
                        begin
                            s_next.cnt = 6'd0;
                        end
                        else
                        begin
                            s_next.start = 1'b0;
                            s_next.state = ADCS_ST_IDLE;
                        end
                    end
                    else
                    begin
                        s_next.cnt = s_reg.cnt + 6'd1;
                    end
                end
            end
            default:
            begin
                s_next.state = ADCS_ST_IDLE;
            end
        endcase

        // disabling returns to idle, clears the start bit and holds the prescaler at zero
        if (!s_next.enable)
        begin
            s_next.state = ADCS_ST_IDLE;
            s_next.start = 1'b0;
            // an aborted conversion has no sample instant
            s_next.hold_pulse = 1'b0;
        end
        // prescaler runs only for a conversion
        s_next.run = (s_next.state != ADCS_ST_IDLE);

        // ----------------------------------------
        // channel and reference locking
        // ----------------------------------------
        // locked except final converter cycle
        // already started conversion unaffected
        // tracking in the final cycle lets a free-running successor pick up a late change
        track = (s_reg.state != ADCS_ST_CONV) || (s_reg.cnt == (total - 6'd1));
        if (s_reg.enable && track)
        begin
            s_next.active_sel = s_next.hold_sel;
        end

        // ----------------------------------------
        // result-ready flag and interrupt
        // ----------------------------------------
        // flag set regardless of enable; set wins over clear
        s_next.flag = (s_reg.flag & ~flag_clr) | flag_set;
        // interrupt needs flag and both enables
        s_next.irq = s_next.flag & s_next.rdy_ie & global_int_enable_in;
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------
    // outputs, all from flip-flops
    // ----------------------------------------
    assign rd_data_out = s_reg.rd_data;
    assign active_sel_out = s_reg.active_sel;
    assign sample_hold_out = s_reg.hold_pulse;
    // converting is the only state code with its upper bit set
    assign conv_active_out = s_reg.state[1];
    assign result_event_out = s_reg.res_event;
    assign irq_out = s_reg.irq;

endmodule // adcs_sequencer

// >>> bench/adcs_sequencer_checker.sv
// port-level assertions for the conversion sequencer
`timescale 1ns/10ps
`include "adcs_consts.svh"

module adcs_sequencer_checker
    import adcs_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire adcs_bus_t bus_in,
    input wire logic [15:0] rd_data_out,
    input wire logic global_int_enable_in,
    input wire logic event_in,
    input wire logic [9:0] sar_result_in,
    input wire logic over_range_in,
    input wire adcs_sel_t active_sel_out,
    input wire logic sample_hold_out,
    input wire logic conv_active_out,
    input wire logic result_event_out,
    input wire logic irq_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    // ----
    // sequences
    // ----
    sequence s_conv_start;
        !conv_active_out ##1 conv_active_out;
    endsequence

    // two quiet cycles after the read so a fresh completion cannot re-raise the flag
    sequence s_result_read;
        bus_in.rd && bus_in.addr == `ADCS_OFF_RESULT ##1 !result_event_out ##1 !result_event_out;
    endsequence

    // ----
    // assertions
    // ----
    // global enable gate
    AST_IRQ_GLOBAL: assert property (irq_out |-> $past(global_int_enable_in))
        else $error("interrupt raised without global enable");
    AST_EVENT_PULSE: assert property (result_event_out |=> !result_event_out)
        else $error("result event longer than one cycle");
    AST_EVENT_AFTER_CONV: assert property (result_event_out |-> $past(conv_active_out))
        else $error("result event without a conversion");
    AST_HOLD_IN_CONV: assert property (sample_hold_out |-> conv_active_out && $past(conv_active_out))
        else $error("sample instant outside a conversion");
    AST_HOLD_NOT_EARLY: assert property (s_conv_start |-> !sample_hold_out [*3])
        else $error("sample instant too early");
    AST_EVENT_NOT_EARLY: assert property (s_conv_start |-> !result_event_out [*8])
        else $error("conversion ended too early");
    AST_SEL_LOCKED: assert property (sample_hold_out |-> $stable(active_sel_out))
        else $error("selection moved at the sample instant");
    AST_RD_IDLE: assert property (!$past(bus_in.rd) |-> rd_data_out == 16'h0000)
        else $error("read data outside a read answer");
    AST_RD_UNMAPPED: assert property ($past(bus_in.rd) && $past(bus_in.addr) > `ADCS_OFF_ACTIVE
        |-> rd_data_out == 16'h0000)
        else $error("unmapped read not zero");
    AST_READ_DROPS_IRQ: assert property (s_result_read |-> !irq_out)
        else $error("interrupt stays after result read");
endmodule // adcs_sequencer_checker

// >>> bench/adcs_front_model.sv
// analog front end and event routing stand-in for the sequencer bench
`timescale 1ns/10ps

module adcs_front_model
    import adcs_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire adcs_sel_t active_sel_in,
    input wire logic sample_hold_in,
    input wire logic ev_req_in,
    output logic event_out,
    output logic [9:0] sar_result_out,
    output logic over_range_out
);
    // code built from the selection at the sample instant, so a late channel change shows
    // top channel over range
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            event_out <= 1'b0;
            sar_result_out <= 10'h000;
            over_range_out <= 1'b0;
        end
        else
        begin
            event_out <= ev_req_in;
            if (sample_hold_in)
            begin
                sar_result_out <= {active_sel_in.input_channel_select, active_sel_in.reference_select, 3'h5};
                over_range_out <= (active_sel_in.input_channel_select == 5'h1f);
            end
        end
    end
endmodule // adcs_front_model

// >>> bench/test_adcs_sequencer.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/10ps
`include "adcs_consts.svh"

module test_adcs_sequencer;
    import adcs_pkg::*;
    logic sys_clk_in, rst_b_in, gie, ev_req, ev, ovr, hold, act, evt, irq;
    adcs_bus_t bus;
    logic [15:0] rd_data;
    logic [9:0] sar;
    adcs_sel_t sel;
    logic [2:0] dv;
    logic [3:0] sd, sl;
    logic [4:0] ch, nc;
    logic [1:0] rf;
    logic prev_act;
    int fails, n_compared, cyc, t_start, t_rise, t_fall, t_hold, t_evt, t_evt_p, n_evt, n0, f, seed;

    adcs_sequencer dut_u (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .bus_in(bus), .rd_data_out(rd_data),
        .global_int_enable_in(gie), .event_in(ev), .sar_result_in(sar), .over_range_in(ovr),
        .active_sel_out(sel), .sample_hold_out(hold), .conv_active_out(act), .result_event_out(evt),
        .irq_out(irq));
    adcs_front_model far_u (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .active_sel_in(sel),
        .sample_hold_in(hold), .ev_req_in(ev_req), .event_out(ev), .sar_result_out(sar),
        .over_range_out(ovr));

    initial
    begin
        sys_clk_in = 1'b0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end

    // ----
    // timing monitor, sees pre-edge values
    // ----
    always @(posedge sys_clk_in)
    begin
        cyc = cyc + 1;
        if (bus.wr && bus.addr == `ADCS_OFF_COMMAND && bus.wdata[0] && !act)
            t_start = cyc;
        if (act && !prev_act)
            t_rise = cyc;
        if (!act && prev_act)
            t_fall = cyc;
        if (hold)
            t_hold = cyc;
        if (evt)
        begin
            n_evt = n_evt + 1;
            t_evt_p = t_evt;
            t_evt = cyc;
        end
        prev_act = act;
    end

    // ----
    // helpers
    // ----
    function automatic logic [15:0] exp_res(input logic [4:0] c, input logic [1:0] r);
        exp_res = (c == 5'h1f) ? 16'h03ff : {6'h00, c, r, 3'h5};
    endfunction

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge sys_clk_in);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge sys_clk_in);
        bus.wr <= 1'b0;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        @(posedge sys_clk_in);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge sys_clk_in);
        bus.rd <= 1'b0;
        #1 chk(rd_data, e);
    endtask

    task automatic irq_is(input logic e);
        repeat (2) @(posedge sys_clk_in);
        #1 chk({15'h0000, irq}, {15'h0000, e});
    endtask

    task automatic wait_evt(input int target);
        int k;
        k = 0;
        while (n_evt < target && k < 6000)
        begin
            @(posedge sys_clk_in);
            k++;
        end
        if (n_evt < target)
        begin
            fails++;
            $display("MISMATCH t=%0t no completion seen", $time);
            close_out();
        end
    endtask

    // ----
    // main sequence
    // ----
    initial
    begin
        seed = 57;
        {fails, n_compared, cyc, t_start, t_rise, t_fall, t_hold, t_evt, t_evt_p, n_evt} = '0;
        prev_act = 1'b0;
        bus = '0;
        gie = 1'b0;
        ev_req = 1'b0;
        rst_b_in = 1'b0;
        repeat (12) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        for (int a = 0; a < 16; a++)
            rchk(4'(a), 16'h0000);
        wr(`ADCS_OFF_CHANSEL, 16'h0005);
        wr(`ADCS_OFF_REFCFG, 16'h0001);
        wr(`ADCS_OFF_COMMAND, 16'h0001);
        rchk(`ADCS_OFF_ACTIVE, 16'h0000);
        rchk(`ADCS_OFF_COMMAND, 16'h0000);
        wr(`ADCS_OFF_CTRL, 16'h0001);
        rchk(`ADCS_OFF_ACTIVE, 16'h0105);
        // single conversions, random timing, every divider reachable
        for (int i = 0; i < 6; i++)
        begin
            dv = 3'($unsigned($random(seed)) % 8);
            sd = 4'($unsigned($random(seed)) % 4);
            sl = 4'($unsigned($random(seed)) % 4);
            ch = (i == 5) ? 5'h1f : 5'($random(seed));
            rf = 2'(i % 3);
            f = 2 << dv;
            nc = ch ^ 5'h0a;
            wr(`ADCS_OFF_CHANSEL, {11'h000, ch});
            wr(`ADCS_OFF_REFCFG, {9'h000, dv, 2'b00, rf});
            wr(`ADCS_OFF_SAMPCFG, {8'h00, sl, sd});
            n0 = n_evt;
            wr(`ADCS_OFF_COMMAND, 16'h0001);
            rchk(`ADCS_OFF_COMMAND, 16'h0001);
            // change one converter cycle after start
            repeat (f / 2 + 2 + f) @(posedge sys_clk_in);
            wr(`ADCS_OFF_CHANSEL, {11'h000, nc});
            wr(`ADCS_OFF_COMMAND, 16'h0001);
            wait_evt(n0 + 1);
            // the rise is seen one edge after it happens
            chk(16'(t_rise - t_start), 16'(f / 2 + 3));
            chk(16'(t_hold - t_rise), 16'((2 + sd + sl) * f));
            rchk(`ADCS_OFF_COMMAND, 16'h0000);
            rchk(`ADCS_OFF_FLAGS, 16'h0001);
            rchk(`ADCS_OFF_RESULT, exp_res(ch, rf));
            rchk(`ADCS_OFF_FLAGS, 16'h0000);
            rchk(`ADCS_OFF_ACTIVE, {6'h00, rf, 3'h0, nc});
            chk(16'(t_fall - t_rise), 16'((13 + sd + sl) * f));
        end
        wr(`ADCS_OFF_REFCFG, 16'h0000);
        wr(`ADCS_OFF_SAMPCFG, 16'h0000);
        wr(`ADCS_OFF_EVCTRL, 16'h0001);
        n0 = n_evt;
        @(posedge sys_clk_in);
        ev_req <= 1'b1;
        wait_evt(n0 + 1);
        repeat (60) @(posedge sys_clk_in);
        ev_req <= 1'b0;
        chk(16'(n_evt - n0), 16'h0001);
        rchk(`ADCS_OFF_COMMAND, 16'h0000);
        wr(`ADCS_OFF_EVCTRL, 16'h0000);
        ev_req <= 1'b1;
        repeat (10) @(posedge sys_clk_in);
        ev_req <= 1'b0;
        repeat (60) @(posedge sys_clk_in);
        chk(16'(n_evt - n0), 16'h0001);
        wr(`ADCS_OFF_INTCTRL, 16'h0001);
        irq_is(1'b0);
        @(posedge sys_clk_in);
        gie <= 1'b1;
        irq_is(1'b1);
        wr(`ADCS_OFF_INTCTRL, 16'h0000);
        irq_is(1'b0);
        wr(`ADCS_OFF_INTCTRL, 16'h0001);
        irq_is(1'b1);
        rchk(`ADCS_OFF_RESULT, exp_res(nc, 2'h0));
        irq_is(1'b0);
        // free running, period sixteen converter cycles
        wr(`ADCS_OFF_SAMPCFG, 16'h0021);
        wr(`ADCS_OFF_CTRL, 16'h0003);
        n0 = n_evt;
        wr(`ADCS_OFF_COMMAND, 16'h0001);
        wait_evt(n0 + 1);
        wr(`ADCS_OFF_CHANSEL, 16'h0003);
        wait_evt(n0 + 2);
        rchk(`ADCS_OFF_RESULT, exp_res(nc, 2'h0));
        wait_evt(n0 + 3);
        rchk(`ADCS_OFF_RESULT, exp_res(5'h03, 2'h0));
        chk(16'(t_evt - t_evt_p), 16'd32);
        rchk(`ADCS_OFF_COMMAND, 16'h0001);
        wr(`ADCS_OFF_CTRL, 16'h0000);
        rchk(`ADCS_OFF_COMMAND, 16'h0000);
        close_out();
    end
endmodule // test_adcs_sequencer

bind adcs_sequencer adcs_sequencer_checker chk_u (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .bus_in(bus_in), .rd_data_out(rd_data_out), .global_int_enable_in(global_int_enable_in),
    .event_in(event_in), .sar_result_in(sar_result_in), .over_range_in(over_range_in),
    .active_sel_out(active_sel_out), .sample_hold_out(sample_hold_out), .conv_active_out(conv_active_out),
    .result_event_out(result_event_out), .irq_out(irq_out));
